// ---- core/fpc_pkg.sv ----
// Purpose: Shared constants for the flash program control block
// Assumes: One clock (CPU machine cycle), byte-wide special-function bus
// Notes: Offsets, field positions, command values and windows live here only
package fpc_pkg;

    // Special-function addresses
    localparam logic [7:0] FPC_CTRL_ADDR = 8'hD1;
    localparam logic [7:0] FPC_STAT_ADDR = 8'hD3;

    // Reset values
    localparam logic [7:0] FPC_CTRL_RST = 8'h00;
    localparam logic [7:0] FPC_STAT_RST = 8'h00;

    // Control register field positions
    localparam int FPC_CMD_MSB = 7;
    localparam int FPC_CMD_LSB = 4;
    localparam int FPC_FPS_BIT = 3;
    localparam int FPC_MOD_MSB = 2;
    localparam int FPC_MOD_LSB = 1;
    localparam int FPC_BUSY_BIT = 0;

    // Status register field positions
    localparam int FPC_SEQUENCE_ERROR_FLAG_BIT = 1;
    localparam int FPC_LOADED_BIT = 0;

    // Unlock command values
    localparam logic [3:0] FPC_CMD_FIRST = 4'h5;
    localparam logic [3:0] FPC_CMD_SECOND = 4'hA;

    // Flash space modes
    typedef enum logic [1:0] {
        FPC_MODE_USER = 2'b00,
        FPC_MODE_XROW = 2'b01,
        FPC_MODE_SECB = 2'b10,
        FPC_MODE_LRST = 2'b11
    } fpc_mode_e;

    // Code-read windows
    localparam logic [15:0] FPC_XROW_BASE = 16'hFF80;
    localparam logic [15:0] FPC_SECB_ADDR = 16'h0000;

    // Latch address split
    localparam int FPC_BYTE_MSB = 6;
    localparam int FPC_PAGE_LSB = 7;
    localparam int FPC_ADDR_MSB = 15;

    // Launch happens this many machine cycles after the second write
    localparam logic [1:0] FPC_LAUNCH_CYCLES = 2'h2;

endpackage : fpc_pkg

// ---- core/fpc_flash_ctrl.sv ----
// Purpose: Flash control/status registers, latch mapping and unlock launch
// Assumes: SFR and data-space strobes are single-cycle pulses on clk_i
// Notes: Flash array and its latches sit outside; this block only steers them
`timescale 1ns/1ps

// Operation
// - Control register at D1h with four fields
// - Status register at D3h, error and loaded
// - Both registers clear to zero on reset
// - Unlock field acts as write protection
// - Launch only after ordered 5 then A
// - Mode 00: 5 idle, A programs user
// - Select clear: latches unreachable, user read-only
// - Select set maps latches into data space
// - Latch writes accepted across 0000h-FFFFh
// - Bits 6-0 byte, 15-7 page
// - Select overrides external RAM select bit
// - Mode bits map space for code reads
// - Mode 11 clears latches on unlock
// - Bad activation sequence sets error flag
// - Error cleared by software or good sequence
// - First latch write sets loaded flag
// - Successful activation clears loaded flag
// - Busy shows programming, hardware clears it
// - Programming starts second cycle after A
module fpc_flash_ctrl (
    input wire logic clk_i,                 // Machine-cycle clock
    input wire logic rstn_i,                // Async reset, active low
    input wire logic [7:0] sfr_addr_i,      // SFR address
    input wire logic sfr_wr_i,              // SFR write strobe
    input wire logic sfr_rd_i,              // SFR read strobe
    input wire logic [7:0] sfr_wdata_i,     // SFR write data
    output logic [7:0] sfr_rdata_o,         // SFR read data, registered
    input wire logic xdata_wr_i,            // Data-space write strobe
    input wire logic [15:0] xdata_addr_i,   // Data-space address
    input wire logic [7:0] xdata_wdata_i,   // Data-space write data
    input wire logic aux_external_ram_select_i,          // External RAM select from auxiliary register
    output logic eram_wr_o,                 // Write to on-chip expanded RAM
    output logic xram_wr_o,                 // Write to external data memory
    output logic latch_wr_o,                // Column latch write pulse, registered
    output logic [6:0] latch_byte_o,        // Byte within page
    output logic [8:0] latch_page_o,        // Target page
    output logic [7:0] latch_data_o,        // Latch write data
    input wire logic [15:0] code_addr_i,    // Code-read address
    output fpc_pkg::fpc_mode_e code_space_o, // Flash space mapped for code reads
    output logic code_hit_o,                // Code-read address falls in mapped space
    output logic prog_start_o,              // Programming launch pulse
    output fpc_pkg::fpc_mode_e prog_space_o, // Space to program
    output logic latch_clear_o,             // Column latch reset pulse
    input wire logic prog_done_i            // Array finished programming
);
    import fpc_pkg::*;

    // Unlock tracker states
    typedef enum logic [0:0] {
        FPC_UL_IDLE = 1'b0,
        FPC_UL_ARMED = 1'b1
    } fpc_ul_e;

    // Registered state
    logic [3:0] cmd_ff;            // Unlock command field as last written
    logic fps_ff;                  // Latch-space select
    fpc_mode_e mode_ff;            // Flash space mode
    logic busy_ff;                 // Programming busy
    logic sequence_error_flag_ff;               // Sequence error
    logic loaded_ff;               // Latches hold data
    fpc_ul_e ul_ff;                // Unlock tracker
    fpc_mode_e armed_mode_ff;      // Mode seen with the first write
    logic [1:0] launch_cnt_ff;     // Cycles until launch, zero when idle
    fpc_mode_e launch_mode_ff;     // Operation waiting to launch
    logic [7:0] rdata_ff;          // Read data holding register
    logic latch_wr_ff;             // Latch strobe
    logic [6:0] latch_byte_ff;     // Latch byte index
    logic [8:0] latch_page_ff;     // Latch page
    logic [7:0] latch_data_ff;     // Latch data
    logic start_ff;                // Launch pulse
    logic clear_ff;                // Latch reset pulse

    // Next-state values
    fpc_ul_e nxt_ul;
    logic nxt_sequence_error_flag;
    logic nxt_loaded;
    logic nxt_busy;
    logic [1:0] nxt_launch_cnt;

    // Address decode used for both read and write
    function automatic logic fpc_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
        fpc_hit = (addr == reg_addr);
    endfunction : fpc_hit

    wire ctrl_wr = sfr_wr_i & fpc_hit(sfr_addr_i, FPC_CTRL_ADDR);
    wire stat_wr = sfr_wr_i & fpc_hit(sfr_addr_i, FPC_STAT_ADDR);
    wire other_sfr_wr = sfr_wr_i & ~ctrl_wr;

    // Written fields split out
    wire [3:0] wr_cmd = sfr_wdata_i[FPC_CMD_MSB:FPC_CMD_LSB];
    wire [1:0] wr_mode = sfr_wdata_i[FPC_MOD_MSB:FPC_MOD_LSB];
    wire is_first = ctrl_wr & (wr_cmd == FPC_CMD_FIRST);
    wire is_second = ctrl_wr & (wr_cmd == FPC_CMD_SECOND);

    // ordered pair completes only from the armed state
    // mode must match the one given with the first write
    // A launch already counting down or in progress refuses another
    wire seq_ok = is_second & (ul_ff == FPC_UL_ARMED) & (wr_mode == armed_mode_ff)
                  & ~busy_ff & (launch_cnt_ff == 2'h0);
    // anything that breaks the pair is an error
    // stray second write counts as a broken pair
    wire seq_bad = (is_second & ~seq_ok)
                   | ((ul_ff == FPC_UL_ARMED) & ((ctrl_wr & ~is_second) | other_sfr_wr | xdata_wr_i));

    // latches own data-space writes while select is set
    // every address of the 64 KB range is accepted
    wire latch_hit = xdata_wr_i & fps_ff;
    // select wins over the external RAM select bit
    assign eram_wr_o = xdata_wr_i & ~fps_ff & ~aux_external_ram_select_i;
    assign xram_wr_o = xdata_wr_i & ~fps_ff & aux_external_ram_select_i;

    // window check for the mapped code space
    // software reads these through code reads after choosing the mode
    wire in_xrow = (code_addr_i >= FPC_XROW_BASE);
    wire in_secb = (code_addr_i == FPC_SECB_ADDR);
    assign code_space_o = mode_ff;
    assign code_hit_o = (mode_ff == FPC_MODE_USER)
                        | ((mode_ff == FPC_MODE_XROW) & in_xrow)
                        | ((mode_ff == FPC_MODE_SECB) & in_secb);

    // Register images for reads
    wire [7:0] ctrl_img = {cmd_ff, fps_ff, mode_ff, busy_ff};
    wire [7:0] stat_img = {6'h00, sequence_error_flag_ff, loaded_ff};
    wire [7:0] rd_mux = fpc_hit(sfr_addr_i, FPC_CTRL_ADDR) ? ctrl_img :
                        fpc_hit(sfr_addr_i, FPC_STAT_ADDR) ? stat_img : 8'h00;

    // Launch moment reached this cycle
    wire launch_now = (launch_cnt_ff == 2'h1);

    // Unlock tracker next state
    always_comb begin
        nxt_ul = ul_ff;
        unique case (ul_ff)
            FPC_UL_IDLE: begin
                // first write only arms, no action
                if (is_first) begin
                    nxt_ul = FPC_UL_ARMED;
                end
            end
            FPC_UL_ARMED: begin
                // any other write in between disarms; a repeated first write re-arms
                if (ctrl_wr | other_sfr_wr | xdata_wr_i) begin
                    nxt_ul = is_first ? FPC_UL_ARMED : FPC_UL_IDLE;
                end
            end
        endcase
    end

    // Status flag next values
    always_comb begin
        nxt_sequence_error_flag = sequence_error_flag_ff;
        if (stat_wr & ~sfr_wdata_i[FPC_SEQUENCE_ERROR_FLAG_BIT]) begin
            nxt_sequence_error_flag = 1'b0;
        end
        // a good sequence cancels older errors
        if (seq_ok) begin
            nxt_sequence_error_flag = 1'b0;
        end
        if (seq_bad) begin
            nxt_sequence_error_flag = 1'b1;
        end
        nxt_loaded = loaded_ff;
        // success of either kind clears the loaded flag
        if (seq_ok) begin
            nxt_loaded = 1'b0;
        end
        if (latch_hit) begin
            nxt_loaded = 1'b1;
        end
    end

    // Launch countdown and busy
    always_comb begin
        nxt_launch_cnt = launch_cnt_ff;
        // count down to the second cycle after the write
        if (seq_ok) begin
            nxt_launch_cnt = FPC_LAUNCH_CYCLES;
        end else if (launch_cnt_ff != 2'h0) begin
            nxt_launch_cnt = launch_cnt_ff - 2'h1;
        end
        nxt_busy = busy_ff;
        // hardware clears when the array reports done
        if (busy_ff & prog_done_i) begin
            nxt_busy = 1'b0;
        end
        // set while a program operation runs
        if (launch_now & (launch_mode_ff != FPC_MODE_LRST)) begin
            nxt_busy = 1'b1;
        end
    end

    // Control register; busy bit is hardware-owned
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd_ff <= FPC_CTRL_RST[FPC_CMD_MSB:FPC_CMD_LSB];
            fps_ff <= FPC_CTRL_RST[FPC_FPS_BIT];
            mode_ff <= fpc_mode_e'(FPC_CTRL_RST[FPC_MOD_MSB:FPC_MOD_LSB]);
            busy_ff <= FPC_CTRL_RST[FPC_BUSY_BIT];
        end else begin
            // any command value just updates the fields
            if (ctrl_wr) begin
                cmd_ff <= wr_cmd;
                fps_ff <= sfr_wdata_i[FPC_FPS_BIT];
                mode_ff <= fpc_mode_e'(wr_mode);
            end
            busy_ff <= nxt_busy;
        end
    end

    // Status register
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sequence_error_flag_ff <= FPC_STAT_RST[FPC_SEQUENCE_ERROR_FLAG_BIT];
            loaded_ff <= FPC_STAT_RST[FPC_LOADED_BIT];
        end else begin
            sequence_error_flag_ff <= nxt_sequence_error_flag;
            loaded_ff <= nxt_loaded;
        end
    end

    // Unlock tracker and armed mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ul_ff <= FPC_UL_IDLE;
            armed_mode_ff <= FPC_MODE_USER;
        end else begin
            ul_ff <= nxt_ul;
            // the first write remembers which space it unlocks
            if (is_first) begin
                armed_mode_ff <= fpc_mode_e'(wr_mode);
            end
        end
    end

    // Launch pipeline and pulses
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            launch_cnt_ff <= 2'h0;
            launch_mode_ff <= FPC_MODE_USER;
            start_ff <= 1'b0;
            clear_ff <= 1'b0;
        end else begin
            launch_cnt_ff <= nxt_launch_cnt;
            if (seq_ok) begin
                launch_mode_ff <= armed_mode_ff;
            end
            // program user / other space at launch
            start_ff <= launch_now & (launch_mode_ff != FPC_MODE_LRST);
            // mode 11 resets the latches instead
            clear_ff <= launch_now & (launch_mode_ff == FPC_MODE_LRST);
        end
    end

    // Latch write port, registered so data lines come from flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            latch_wr_ff <= 1'b0;
            latch_byte_ff <= 7'h00;
            latch_page_ff <= 9'h000;
            latch_data_ff <= 8'h00;
        end else begin
            // select clear keeps writes away from latches
            latch_wr_ff <= latch_hit;
            // split address into byte and page
            if (latch_hit) begin
                latch_byte_ff <= xdata_addr_i[FPC_BYTE_MSB:0];
                latch_page_ff <= xdata_addr_i[FPC_ADDR_MSB:FPC_PAGE_LSB];
                latch_data_ff <= xdata_wdata_i;
            end
        end
    end

    // Read data holds until the next read
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_ff <= 8'h00;
        end else if (sfr_rd_i) begin
            rdata_ff <= rd_mux;
        end
    end

    // Output wiring
    assign sfr_rdata_o = rdata_ff;
    assign latch_wr_o = latch_wr_ff;
    assign latch_byte_o = latch_byte_ff;
    assign latch_page_o = latch_page_ff;
    assign latch_data_o = latch_data_ff;
    assign prog_start_o = start_ff;
    assign prog_space_o = launch_mode_ff;
    assign latch_clear_o = clear_ff;

    // Checks beside the logic they guard
    launch_delay_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_ok && armed_mode_ff != FPC_MODE_LRST |-> ##3 prog_start_o)
        else $error("program launch not two cycles after unlock");

    latch_reset_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_ok && armed_mode_ff == FPC_MODE_LRST |-> ##3 (latch_clear_o && !prog_start_o))
        else $error("latch reset not issued for mode 11");

    stray_second_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        is_second && ul_ff == FPC_UL_IDLE && launch_cnt_ff == 2'h0 |-> ##1 sequence_error_flag_ff ##1 !prog_start_o)
        else $error("stray second write launched or went unflagged");

    other_cmd_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        ctrl_wr && !is_first && !is_second && launch_cnt_ff == 2'h0
        |-> ##1 (ul_ff == FPC_UL_IDLE && launch_cnt_ff == 2'h0) ##1 (!prog_start_o && !latch_clear_o))
        else $error("unrelated command affected unlock");

    error_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_ok |=> !sequence_error_flag_ff)
        else $error("good sequence left error flag set");

    loaded_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        latch_hit |=> (loaded_ff && latch_wr_o && latch_data_o == $past(xdata_wdata_i)))
        else $error("latch write did not set loaded flag");

    loaded_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        seq_ok && !latch_hit |=> !loaded_ff)
        else $error("successful activation left loaded flag set");

    latch_route_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        xdata_wr_i && fps_ff |-> !eram_wr_o && !xram_wr_o ##1 latch_wr_o)
        else $error("data write not steered to latches");

    no_latch_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        xdata_wr_i && !fps_ff |=> !latch_wr_o)
        else $error("latch written with select clear");

    busy_done_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        busy_ff && prog_done_i && !launch_now |=> !busy_ff)
        else $error("busy not cleared on completion");

    xrow_map_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode_ff == FPC_MODE_XROW && code_addr_i < FPC_XROW_BASE |-> !code_hit_o)
        else $error("extra row window too wide");

endmodule : fpc_flash_ctrl

// ---- test/fpc_flash_model.sv ----
// Purpose: Behavioural flash array and column latches facing the control block
// Assumes: Same machine-cycle clock as the control block
// Notes: Completion delay comes from dly_i so the bench can answer promptly or slowly
`timescale 1ns/1ps
module fpc_flash_model (
    input wire logic clk_i,           // Machine-cycle clock
    input wire logic rstn_i,          // Async reset, active low
    input wire logic latch_wr_i,      // Column latch write pulse
    input wire logic [6:0] latch_byte_i, // Byte within page
    input wire logic latch_clear_i,   // Column latch reset pulse
    input wire logic prog_start_i,    // Programming launch pulse
    input wire logic [7:0] dly_i,     // Cycles until programming completes
    output logic prog_done_o,         // One-cycle completion pulse
    output logic latch_empty_o        // No latch byte loaded
);
    logic [127:0] filled_ff; // One flag per latch byte
    logic [7:0] cnt_ff;      // Cycles left of a running program
    assign latch_empty_o = (filled_ff == 128'h0);
    // Latch image and programming timer; a short delay is the harshest case
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            filled_ff <= 128'h0;
            cnt_ff <= 8'h00;
            prog_done_o <= 1'b0;
        end else begin
            prog_done_o <= (cnt_ff == 8'h01);
            if (prog_start_i) begin
                cnt_ff <= dly_i;
            end else if (cnt_ff != 8'h00) begin
                cnt_ff <= cnt_ff - 8'h01;
            end
            if (latch_clear_i) begin
                filled_ff <= 128'h0;
            end else if (latch_wr_i) begin
                filled_ff[latch_byte_i] <= 1'b1;
            end
        end
    end
endmodule : fpc_flash_model

// ---- test/testbench.sv ----
// Purpose: Self-checking bench for the flash program control block
// Assumes: Inputs move 1 ns after the rising edge; the monitor compares reads and latch writes at negedge
// Notes: Reads and latch writes queue their expected values for the monitor
`timescale 1ns/1ps
module testbench;
    import fpc_pkg::*;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, xdata_wdata_i = 8'h00, dly = 8'h03;
    logic sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, xdata_wr_i = 1'b0, aux_external_ram_select_i = 1'b0;
    logic [15:0] xdata_addr_i = 16'h0000, code_addr_i = 16'h0000;
    logic [7:0] sfr_rdata_o, latch_data_o;
    logic eram_wr_o, xram_wr_o, latch_wr_o, prog_start_o, latch_clear_o, prog_done_i, code_hit_o, latch_empty;
    logic [6:0] latch_byte_o;
    logic [8:0] latch_page_o;
    fpc_mode_e code_space_o, prog_space_o;
    logic [7:0] rq[$];   // Expected read data
    logic [23:0] lq[$];  // Expected page, byte and data of latch writes
    logic rd_seen = 1'b0;
    int err_count = 0, num_checks = 0, n_start = 0, n_clr = 0;
    logic [15:0] ca[5] = '{16'h0000, 16'h0001, 16'hFF7F, 16'hFF80, 16'hFFFF};
    always #12.5 clk_i = ~clk_i;
    fpc_flash_ctrl dut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
        .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .xdata_wr_i(xdata_wr_i),
        .xdata_addr_i(xdata_addr_i), .xdata_wdata_i(xdata_wdata_i), .aux_external_ram_select_i(aux_external_ram_select_i),
        .eram_wr_o(eram_wr_o), .xram_wr_o(xram_wr_o), .latch_wr_o(latch_wr_o), .latch_byte_o(latch_byte_o),
        .latch_page_o(latch_page_o), .latch_data_o(latch_data_o), .code_addr_i(code_addr_i),
        .code_space_o(code_space_o), .code_hit_o(code_hit_o), .prog_start_o(prog_start_o),
        .prog_space_o(prog_space_o), .latch_clear_o(latch_clear_o), .prog_done_i(prog_done_i));
    fpc_flash_model model (.clk_i(clk_i), .rstn_i(rstn_i), .latch_wr_i(latch_wr_o), .latch_byte_i(latch_byte_o),
        .latch_clear_i(latch_clear_o), .prog_start_i(prog_start_o), .dly_i(dly), .prog_done_o(prog_done_i),
        .latch_empty_o(latch_empty));
    // Compare one value, count and report
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check
    // Drop all strobes and let n cycles pass
    task automatic idle(input int n);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        xdata_wr_i = 1'b0;
        repeat (n) begin
            @(posedge clk_i);
            #1;
        end
    endtask : idle
    // One SFR cycle; for a read, data is the expected answer
    task automatic bus(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        xdata_wr_i = 1'b0;
        sfr_wr_i = wr;
        sfr_rd_i = !wr;
        sfr_addr_i = addr;
        sfr_wdata_i = data;
        if (!wr) rq.push_back(data);
        @(posedge clk_i);
        #1;
    endtask : bus
    // One data-space write; sel says whether latches are mapped
    task automatic xw(input logic [15:0] addr, input logic sel);
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        xdata_wr_i = 1'b1;
        xdata_addr_i = addr;
        xdata_wdata_i = 8'($urandom);
        if (sel) lq.push_back({addr, xdata_wdata_i});
        #1;
        check(24'({xram_wr_o, eram_wr_o}), 24'({!sel && aux_external_ram_select_i, !sel && !aux_external_ram_select_i}));
        @(posedge clk_i);
        #1;
    endtask : xw
    // Load a latch byte, unlock in mode m, follow the launch to its end
    task automatic run_seq(input logic [1:0] m, input logic [7:0] d);
        dly = d;
        xw(16'($urandom), 1'b1);
        // back-to-back pair with the same mode
        bus(1'b1, FPC_CTRL_ADDR, {FPC_CMD_FIRST, 1'b1, m, 1'b0});
        bus(1'b1, FPC_CTRL_ADDR, {FPC_CMD_SECOND, 1'b1, m, 1'b0});
        idle(1);
        check(24'(prog_start_o), 24'h0);
        idle(1);
        check(24'({prog_start_o, latch_clear_o, prog_space_o}), 24'({m != 2'b11, m == 2'b11, m}));
        bus(1'b0, FPC_CTRL_ADDR, {FPC_CMD_SECOND, 1'b1, m, m != 2'b11});
        idle(1);
        for (int i = 0; i < 300 && prog_done_i !== 1'b1 && m != 2'b11; i++) idle(1);
        idle(2);
        bus(1'b0, FPC_CTRL_ADDR, {FPC_CMD_SECOND, 1'b1, m, 1'b0});
        bus(1'b0, FPC_STAT_ADDR, 8'h00);
        idle(2);
        check(24'(latch_empty), 24'(m == 2'b11));
        $display("test launch in mode %0d done", m);
    endtask : run_seq
    // Print counts and the verdict, then stop
    task automatic results;
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : results
    // Monitor: oldest note against each read answer and latch write
    always @(posedge clk_i) rd_seen <= sfr_rd_i;
    always @(negedge clk_i) begin
        if (rd_seen) check(24'(sfr_rdata_o), 24'(rq.pop_front()));
        if (latch_wr_o === 1'b1) check({latch_page_o, latch_byte_o, latch_data_o}, lq.pop_front());
        if (prog_start_o === 1'b1) n_start++;
        if (latch_clear_o === 1'b1) n_clr++;
    end
    // Watchdog well beyond the expected run length
    initial begin
        #(25 * 6000);
        err_count++;
        results();
    end
    initial begin
        void'($urandom(37));
        repeat (2) @(posedge clk_i);
        #1;
        rstn_i = 1'b1;
        bus(1'b0, FPC_CTRL_ADDR, 8'h00);
        bus(1'b0, FPC_STAT_ADDR, 8'h00);
        bus(1'b0, 8'hD2, 8'h00);
        idle(1);
        $display("test reset values done");
        // Modes 00-10 map their windows for code reads; mode 11 maps none
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, FPC_CTRL_ADDR, {4'h0, 1'b0, 2'(m), 1'b0});
            idle(1);
            foreach (ca[i]) begin
                code_addr_i = ca[i];
                #1;
                check(24'({code_space_o, code_hit_o}),
                    24'({2'(m), m == 0 || (m == 1 && ca[i] >= 16'hFF80) || (m == 2 && ca[i] == 16'h0000)}));
            end
            idle(1);
        end
        $display("test code windows done");
        // Select clear steers by the aux bit; select set loads latches
        for (int k = 0; k < 4; k++) begin
            aux_external_ram_select_i = k[0];
            xw(16'($urandom), 1'b0);
        end
        bus(1'b1, FPC_CTRL_ADDR, 8'h08);
        xw(16'h0000, 1'b1);
        xw(16'hFFFF, 1'b1);
        xw(16'($urandom), 1'b1);
        bus(1'b0, FPC_STAT_ADDR, 8'h01);
        idle(1);
        $display("test latch mapping done");
        // Broken sequences: stray A, write between, mode change, other value
        for (int e = 0; e < 4; e++) begin
            bus(1'b1, FPC_CTRL_ADDR, {e == 0 ? FPC_CMD_SECOND : FPC_CMD_FIRST, 4'h8});
            if (e == 1) xw(16'($urandom), 1'b1);
            if (e != 3) bus(1'b1, FPC_CTRL_ADDR, {FPC_CMD_SECOND, 1'b1, 2'(e == 2), 1'b0});
            else bus(1'b1, FPC_CTRL_ADDR, 8'h3A);
            idle(2);
            bus(1'b0, FPC_STAT_ADDR, 8'h03);
            bus(1'b1, FPC_STAT_ADDR, 8'hFF);
            bus(1'b0, FPC_STAT_ADDR, 8'h03);
            bus(1'b1, FPC_STAT_ADDR, 8'h00);
            bus(1'b0, FPC_STAT_ADDR, 8'h01);
        end
        bus(1'b0, FPC_CTRL_ADDR, 8'h3A);
        idle(1);
        check(24'(n_start), 24'h0);
        $display("test broken sequences done");
        // Leave an error standing, then good launches in every mode
        bus(1'b1, FPC_CTRL_ADDR, 8'hA8);
        for (int m = 0; m < 4; m++) run_seq(2'(m), m[0] ? 8'h28 : 8'h03);
        check(24'({n_start[7:0], n_clr[7:0]}), 24'h0301);
        results();
    end
endmodule : testbench
